// File: verilog/l2_forward_source_learn.sv
// layer-2 forwarding decision, source check and automatic learning
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "l2_fwd_map.svh"
module l2_forward_source_learn #(
  parameter int PORTS = 11,
  parameter int SERVICES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire l2_fwd_pkg::frame_t frame,
  input wire l2_fwd_pkg::dst_result_t dst,
  input wire l2_fwd_pkg::src_result_t src,
  output l2_fwd_pkg::decision_t decision,
  output l2_fwd_pkg::learn_entry_t learn
);
  if (PORTS < 1 || PORTS > 32 || SERVICES < 1 || SERVICES > 28) begin : g_chk
    $error("unsupported PORTS or SERVICES");
  end

  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
    logic [6:0] fwd_cfg;
    logic [6:0] lrn_cfg;
    logic [31:0] auto_learn_cfg;
    logic [31:0] port_secure_forward_cfg;
    logic [31:0] locked_secure_forward_cfg;
    logic [31:0] learn_copy_cfg;
    logic [31:0] move_log_a;
    logic [8:0] learned_cfg;
    logic [SERVICES-1:0][14:0] service_cfg;
    l2_fwd_pkg::decision_t dec;
    l2_fwd_pkg::learn_entry_t lrn;
  } state_t;

  state_t s;
  state_t next_s;

  logic [31:0] port_bit;
  logic [31:0] port_mask;
  logic svc_en;
  logic [1:0] rx_kind;
  logic [11:0] rx_addr;
  logic unknown;
  logic differs;
  logic mc_skip;
  logic move_unlocked;
  logic move_locked;
  logic sec_drop;
  logic locked_drop;
  logic learn_now;
  logic flood;
  logic [4:0] svc_sel;

  assign port_mask = (PORTS == 32) ? 32'hFFFFFFFF :
                     ((32'h00000001 << PORTS) - 32'h00000001);
  assign port_bit = 32'h00000001 << frame.ingress_port;
  assign svc_sel = frame.service_index;

  // received address: service, glag or logical port
  always_comb begin
    svc_en = 1'b0;
    rx_kind = `KIND_LOGICAL;
    rx_addr = {2'h0, frame.unit_identifier, frame.ingress_port};
    if (frame.aggregated) begin
      rx_kind = `KIND_GLAG;
      rx_addr = {7'h00, frame.global_aggregation_group};
    end
    if (int'(svc_sel) < SERVICES) begin
      svc_en = s.service_cfg[svc_sel][`SVC_EN_BIT];
    end
    if (svc_en) begin
      rx_kind = s.service_cfg[svc_sel][`SVC_KIND_LSB +: 2];
      rx_addr = s.service_cfg[svc_sel][`SVC_ADDR_LSB +: 12];
    end
  end

  // source check
  assign unknown = !src.hit;
  assign differs = (src.kind != rx_kind) || (src.addr != rx_addr);
  assign mc_skip = (src.kind == `KIND_MC_INDEX) &&
                   s.lrn_cfg[`LRN_SKIP_MC_BIT];
  assign move_unlocked = src.hit && !src.locked && differs &&
                         !mc_skip;
  assign move_locked = src.hit && src.locked && differs && !mc_skip &&
                       s.lrn_cfg[`LRN_LMOVE_DET_BIT];
  assign sec_drop = (unknown || move_unlocked) &&
                    (frame.vlan_secure_forward_enable ||
                     |(s.port_secure_forward_cfg & port_bit));
  assign locked_drop = move_locked &&
                       |(s.locked_secure_forward_cfg & port_bit);
  assign learn_now = (unknown || move_unlocked) &&
                     |(s.auto_learn_cfg & port_bit);
  assign flood = !dst.hit && !(frame.vlan_secure_forward_enable &&
                               unknown);

  always_comb begin
    next_s = s;
    // bus address phase
    next_s.act = hsel && htrans[1] && hready;
    next_s.wr = hwrite;
    next_s.addr = haddr[7:0];
    // frame decision, one cycle after the frame
    next_s.dec = '0;
    next_s.lrn = '0;
    if (frame.valid) begin
      next_s.dec.valid = 1'b1;
      next_s.dec.flood = flood;
      next_s.dec.port_group_index = dst.hit ? {dst.kind, dst.addr}
                                            : frame.flood_group;
      next_s.dec.mirror = flood && s.fwd_cfg[`FWD_MIRROR_BIT];
      next_s.dec.flood_host_copy = flood && s.fwd_cfg[`FWD_HCOPY_BIT];
      next_s.dec.flood_host_queue = s.fwd_cfg[`FWD_HQ_LSB +: 3];
      next_s.dec.skip_mask = (dst.hit && dst.entry_vlan_ignore) ||
                             (flood && s.fwd_cfg[`FWD_VIGN_BIT]);
      next_s.dec.mask_select = s.fwd_cfg[`FWD_MODE_BIT];
      next_s.dec.forward_drop = sec_drop || locked_drop;
      next_s.dec.learn_host_copy =
        ((unknown || move_unlocked) && |(s.learn_copy_cfg & port_bit)) ||
        (move_locked && s.lrn_cfg[`LRN_LMOVE_COPY_BIT]);
      next_s.dec.learn_host_queue = s.lrn_cfg[`LRN_HQ_LSB +: 3];
      next_s.dec.age_clear = src.hit &&
        (!src.locked || s.lrn_cfg[`LRN_LAGE_BIT]);
      if (learn_now) begin
        next_s.lrn.write = 1'b1;
        next_s.lrn.update_only = move_unlocked;
        next_s.lrn.entry_valid = 1'b1;
        next_s.lrn.mac = frame.smac;
        next_s.lrn.fid = frame.ingress_filter_id;
        next_s.lrn.kind = rx_kind;
        next_s.lrn.addr = rx_addr;
        next_s.lrn.learned_host_copy = s.learned_cfg[0];
        next_s.lrn.learned_host_queue = s.learned_cfg[3:1];
        next_s.lrn.learned_source_drop = s.learned_cfg[4];
        next_s.lrn.learned_vlan_ignore = s.learned_cfg[5];
        next_s.lrn.learned_mirror = s.learned_cfg[6];
        next_s.lrn.age_interval = s.learned_cfg[8:7];
      end
    end
    // bus data phase write
    if (s.act && s.wr) begin
      if (s.addr == `FWD_CFG_OFS) begin
        next_s.fwd_cfg = hwdata[6:0];
      end else if (s.addr == `LRN_CFG_OFS) begin
        next_s.lrn_cfg = hwdata[6:0];
      end else if (s.addr == `AUTO_LEARN_OFS) begin
        next_s.auto_learn_cfg = hwdata & port_mask;
      end else if (s.addr == `PORT_SECURE_OFS) begin
        next_s.port_secure_forward_cfg = hwdata & port_mask;
      end else if (s.addr == `LOCKED_SECURE_OFS) begin
        next_s.locked_secure_forward_cfg = hwdata & port_mask;
      end else if (s.addr == `LEARN_COPY_OFS) begin
        next_s.learn_copy_cfg = hwdata & port_mask;
      end else if (s.addr == `MOVE_LOG_OFS) begin
        next_s.move_log_a = s.move_log_a & ~hwdata;
      end else if (s.addr == `LEARNED_CFG_OFS) begin
        next_s.learned_cfg = hwdata[8:0];
      end else begin
        for (int i = 0; i < SERVICES; i++) begin
          if (s.addr == 8'(`SERVICE_BASE_OFS + 4 * i)) begin
            next_s.service_cfg[i] = hwdata[14:0];
          end
        end
      end
    end
    // a learned move in the same cycle as a clear still sets its bit
    if (frame.valid && learn_now && move_unlocked) begin
      next_s.move_log_a = next_s.move_log_a |
                          (port_bit & port_mask);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.fwd_cfg <= `FWD_CFG_RST;
      s.lrn_cfg <= `LRN_CFG_RST;
      s.learned_cfg <= `LEARNED_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  // read mux on the latched data-phase address
  always_comb begin
    hrdata = 32'h00000000;
    if (s.act && !s.wr) begin
      if (s.addr == `FWD_CFG_OFS) begin
        hrdata = {25'h0000000, s.fwd_cfg};
      end else if (s.addr == `LRN_CFG_OFS) begin
        hrdata = {25'h0000000, s.lrn_cfg};
      end else if (s.addr == `AUTO_LEARN_OFS) begin
        hrdata = s.auto_learn_cfg;
      end else if (s.addr == `PORT_SECURE_OFS) begin
        hrdata = s.port_secure_forward_cfg;
      end else if (s.addr == `LOCKED_SECURE_OFS) begin
        hrdata = s.locked_secure_forward_cfg;
      end else if (s.addr == `LEARN_COPY_OFS) begin
        hrdata = s.learn_copy_cfg;
      end else if (s.addr == `MOVE_LOG_OFS) begin
        hrdata = s.move_log_a;
      end else if (s.addr == `LEARNED_CFG_OFS) begin
        hrdata = {23'h000000, s.learned_cfg};
      end else begin
        for (int i = 0; i < SERVICES; i++) begin
          if (s.addr == 8'(`SERVICE_BASE_OFS + 4 * i)) begin
            hrdata = {17'h00000, s.service_cfg[i]};
          end
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign decision = s.dec;
  assign learn = s.lrn;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flood_on_miss_a: assert property (frame.valid && !dst.hit &&
    !(frame.vlan_secure_forward_enable && !src.hit)
    |=> decision.valid && decision.flood &&
        decision.port_group_index == $past(frame.flood_group))
    else $error("miss did not flood");
  known_index_a: assert property (frame.valid && dst.hit
    |=> !decision.flood &&
        decision.port_group_index == $past({dst.kind, dst.addr}))
    else $error("known destination index wrong");
  flood_copy_a: assert property (decision.flood_host_copy
    |-> decision.flood && s.fwd_cfg[`FWD_HCOPY_BIT])
    else $error("flood copy without flood");
  skip_mask_a: assert property (frame.valid && dst.hit &&
    dst.entry_vlan_ignore |=> decision.skip_mask)
    else $error("vlan ignore not applied");
  secure_drop_a: assert property (frame.valid && !src.hit &&
    frame.vlan_secure_forward_enable |=> decision.forward_drop)
    else $error("unknown source not dropped");
  locked_drop_a: assert property (frame.valid && src.hit &&
    src.locked && differs && !mc_skip && s.lrn_cfg[`LRN_LMOVE_DET_BIT] &&
    |(s.locked_secure_forward_cfg & port_bit) |=> decision.forward_drop)
    else $error("locked move not dropped");
  learn_insert_a: assert property (frame.valid && !src.hit &&
    |(s.auto_learn_cfg & port_bit)
    |=> learn.write && !learn.update_only &&
        learn.mac == $past(frame.smac))
    else $error("unknown source not learned");
  age_clear_a: assert property (frame.valid && src.hit &&
    !src.locked |=> decision.age_clear)
    else $error("age not cleared");
  locked_skip_a: assert property (frame.valid && src.hit &&
    src.locked && !s.lrn_cfg[`LRN_LMOVE_DET_BIT]
    |=> !decision.forward_drop && !decision.learn_host_copy && !learn.write)
    else $error("locked entry moved without detect");
  locked_copy_a: assert property (frame.valid && move_locked &&
    s.lrn_cfg[`LRN_LMOVE_COPY_BIT] |=> decision.learn_host_copy)
    else $error("locked move not copied");
  mc_skip_a: assert property (frame.valid && src.hit &&
    src.kind == `KIND_MC_INDEX && s.lrn_cfg[`LRN_SKIP_MC_BIT]
    |=> !learn.write)
    else $error("multicast index entry rewritten");
  glag_learn_a: assert property (frame.valid && !src.hit &&
    frame.aggregated && !svc_en && |(s.auto_learn_cfg & port_bit)
    |=> learn.kind == `KIND_GLAG &&
        learn.addr == $past({7'h00, frame.global_aggregation_group}))
    else $error("aggregated source learned wrong");
  moved_sticky_a: assert property (learn.write &&
    learn.update_only |-> |(s.move_log_a & $past(port_bit & port_mask)))
    else $error("move not logged");
  cov_flood_c: cover property (decision.valid && decision.flood);
  cov_learn_c: cover property (learn.write && !learn.update_only);
  cov_move_c: cover property (learn.write && learn.update_only);
  cov_glag_c: cover property (learn.write && learn.kind == `KIND_GLAG);
  cov_drop_copy_c: cover property (decision.forward_drop &&
    decision.learn_host_copy);
endmodule : l2_forward_source_learn

// File: shared/l2_fwd_map.svh
// register offsets, field positions, reset values and codes
`ifndef L2_FWD_MAP_SVH
`define L2_FWD_MAP_SVH
`define FWD_CFG_OFS 8'h00
`define LRN_CFG_OFS 8'h04
`define AUTO_LEARN_OFS 8'h08
`define PORT_SECURE_OFS 8'h0C
`define LOCKED_SECURE_OFS 8'h10
`define LEARN_COPY_OFS 8'h14
`define MOVE_LOG_OFS 8'h18
`define LEARNED_CFG_OFS 8'h1C
`define SERVICE_BASE_OFS 8'h20
`define FWD_MIRROR_BIT 0
`define FWD_HCOPY_BIT 1
`define FWD_HQ_LSB 2
`define FWD_VIGN_BIT 5
`define FWD_MODE_BIT 6
`define LRN_HQ_LSB 0
`define LRN_LMOVE_DET_BIT 3
`define LRN_LMOVE_COPY_BIT 4
`define LRN_LAGE_BIT 5
`define LRN_SKIP_MC_BIT 6
`define SVC_EN_BIT 0
`define SVC_KIND_LSB 1
`define SVC_ADDR_LSB 3
`define FWD_CFG_RST 7'h00
`define LRN_CFG_RST 7'h00
`define LEARNED_CFG_RST 9'h000
`define KIND_LOGICAL 2'h0
`define KIND_GLAG 2'h1
`define KIND_MC_INDEX 2'h3
`endif

// File: shared/l2_fwd_pkg.sv
// types carried between the frame pipeline, mac table and this block
package l2_fwd_pkg;
  typedef struct packed {
    logic valid;
    logic [4:0] ingress_port;
    logic [4:0] unit_identifier;
    logic aggregated;
    logic [4:0] global_aggregation_group;
    logic [4:0] service_index;
    logic [12:0] ingress_filter_id;
    logic [47:0] smac;
    logic vlan_secure_forward_enable;
    logic [13:0] flood_group;
  } frame_t;
  typedef struct packed {
    logic hit;
    logic [1:0] kind;
    logic [11:0] addr;
    logic entry_vlan_ignore;
  } dst_result_t;
  typedef struct packed {
    logic hit;
    logic [1:0] kind;
    logic [11:0] addr;
    logic locked;
  } src_result_t;
  typedef struct packed {
    logic valid;
    logic flood;
    logic [13:0] port_group_index;
    logic mirror;
    logic flood_host_copy;
    logic [2:0] flood_host_queue;
    logic skip_mask;
    logic mask_select;
    logic forward_drop;
    logic learn_host_copy;
    logic [2:0] learn_host_queue;
    logic age_clear;
  } decision_t;
  typedef struct packed {
    logic write;
    logic update_only;
    logic entry_valid;
    logic [47:0] mac;
    logic [12:0] fid;
    logic [1:0] kind;
    logic [11:0] addr;
    logic learned_host_copy;
    logic [2:0] learned_host_queue;
    logic learned_source_drop;
    logic learned_vlan_ignore;
    logic learned_mirror;
    logic [1:0] age_interval;
  } learn_entry_t;
endpackage : l2_fwd_pkg

// File: test/l2_far_model.sv
// far side model: frame pipeline and one-entry mac table source lookup
`timescale 1ns/1ns
module l2_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic lock_entry,
  input wire l2_fwd_pkg::frame_t f_req,
  input wire l2_fwd_pkg::dst_result_t d_req,
  input wire l2_fwd_pkg::learn_entry_t learn,
  output l2_fwd_pkg::frame_t frame,
  output l2_fwd_pkg::dst_result_t dst,
  output l2_fwd_pkg::src_result_t src
);
  logic t_vld;
  logic [47:0] t_mac;
  logic [1:0] t_kind;
  logic [11:0] t_addr;
  logic t_lock;
  logic hit;
  assign hit = t_vld && (t_mac == f_req.smac);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame <= '0;
      dst <= '0;
      src <= '0;
      t_vld <= 1'b0;
      t_mac <= '0;
      t_kind <= '0;
      t_addr <= '0;
      t_lock <= 1'b0;
    end else begin
      // idle fields toggle so stale values are never mistaken for a frame
      frame <= go ? f_req : l2_fwd_pkg::frame_t'({1'b0, ~frame[96:0]});
      dst <= go ? d_req : l2_fwd_pkg::dst_result_t'({1'b0, ~dst[14:0]});
      src <= go ? {hit, t_kind, t_addr, t_lock}
                : l2_fwd_pkg::src_result_t'({1'b0, ~src[14:0]});
      if (learn.write) begin
        t_vld <= 1'b1;
        t_kind <= learn.kind;
        t_addr <= learn.addr;
        if (!learn.update_only) begin
          t_mac <= learn.mac;
          t_lock <= 1'b0;
        end
      end
      if (lock_entry) begin
        t_lock <= 1'b1;
      end
    end
  end
endmodule : l2_far_model

// File: test/l2_forward_source_learn_tb.sv
// self-checking bench for forwarding decision and source learning
`timescale 1ns/1ns
module l2_forward_source_learn_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic go = 1'b0;
  logic lock_entry = 1'b0;
  logic agg = 1'b0;
  l2_fwd_pkg::frame_t f_req = '0;
  l2_fwd_pkg::dst_result_t d_req = '0;
  l2_fwd_pkg::frame_t frame;
  l2_fwd_pkg::dst_result_t dst;
  l2_fwd_pkg::src_result_t src;
  l2_fwd_pkg::decision_t decision;
  l2_fwd_pkg::decision_t dec;
  l2_fwd_pkg::learn_entry_t learn;
  l2_fwd_pkg::learn_entry_t lrn;
  int err_total = 0;
  int n_tests = 0;
  assign hready = hreadyout;
  l2_forward_source_learn dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frame(frame), .dst(dst), .src(src),
    .decision(decision), .learn(learn));
  l2_far_model far (.hclk(hclk), .hresetn(hresetn), .go(go),
    .lock_entry(lock_entry), .f_req(f_req), .d_req(d_req), .learn(learn),
    .frame(frame), .dst(dst), .src(src));
  initial begin
    forever #50 hclk = ~hclk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic send(input logic [4:0] port, input logic [47:0] mac,
                      input logic dh, input logic vi, input logic vs,
                      input logic [4:0] svc);
    l2_fwd_pkg::frame_t fr;
    fr = '0;
    fr.valid = 1'b1;
    fr.ingress_port = port;
    fr.unit_identifier = 5'h02;
    fr.aggregated = agg;
    fr.global_aggregation_group = 5'h07;
    fr.service_index = svc;
    fr.ingress_filter_id = 13'h0ABC;
    fr.smac = mac;
    fr.vlan_secure_forward_enable = vs;
    fr.flood_group = 14'h1234;
    @(posedge hclk);
    go <= 1'b1;
    f_req <= fr;
    d_req <= {dh, 2'h1, 12'h123, vi};
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    @(posedge hclk);
    dec = decision;
    lrn = learn;
  endtask : send
  task automatic t_regs();
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    check({hreadyout, hresp}, 2'h2);
    bus(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h80, 32'hFFFFFFFF);
    bus(1'b0, 8'h80, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h00, 32'h00000077);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h00000077);
  endtask : t_regs
  task automatic t_flood();
    send(5'h00, 48'h0000000000C0, 1'b0, 1'b0, 1'b0, 5'h01);
    check({dec.valid, dec.flood, dec.port_group_index},
          16'hD234);
    check({dec.mirror, dec.flood_host_copy, dec.flood_host_queue},
          5'h1D);
    check({dec.skip_mask, dec.mask_select}, 2'h3);
    send(5'h00, 48'h0000000000C1, 1'b0, 1'b0, 1'b1, 5'h01);
    check({dec.flood, dec.forward_drop}, 2'h1);
    for (int vi = 0; vi < 2; vi++) begin
      send(5'h00, 48'h0000000000C0, 1'b1, vi[0], 1'b0, 5'h01);
      check({dec.flood, dec.flood_host_copy, dec.skip_mask,
             dec.port_group_index},
            {2'b00, vi[0], 14'h1123});
    end
  endtask : t_flood
  task automatic t_learn();
    bus(1'b1, 8'h08, 32'h00000018);
    bus(1'b1, 8'h0C, 32'h00000008);
    bus(1'b1, 8'h14, 32'h00000008);
    bus(1'b1, 8'h04, 32'h0000001E);
    bus(1'b1, 8'h1C, 32'h00000135);
    send(5'h03, 48'hA1A2A3A4A5A6, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, lrn.update_only, lrn.entry_valid, lrn.kind, lrn.addr},
          {3'b101, 2'h0, 12'h043});
    check(lrn.mac, 48'hA1A2A3A4A5A6);
    check({lrn.fid, lrn.learned_host_copy, lrn.learned_host_queue,
           lrn.learned_source_drop, lrn.learned_vlan_ignore,
           lrn.learned_mirror, lrn.age_interval},
          {13'h0ABC, 1'b1, 3'h2, 3'b110, 2'h2});
    check({dec.forward_drop, dec.learn_host_copy, dec.learn_host_queue},
          5'h1E);
  endtask : t_learn
  task automatic t_move();
    send(5'h04, 48'hA1A2A3A4A5A6, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, lrn.update_only, lrn.kind, lrn.addr},
          16'hC044);
    check({dec.age_clear, dec.forward_drop}, 2'h2);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h00000010);
    bus(1'b1, 8'h18, 32'h00000000);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h00000010);
    bus(1'b1, 8'h18, 32'h00000010);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
  endtask : t_move
  task automatic t_locked();
    bus(1'b1, 8'h10, 32'h00000020);
    @(posedge hclk);
    lock_entry <= 1'b1;
    @(posedge hclk);
    lock_entry <= 1'b0;
    send(5'h05, 48'hA1A2A3A4A5A6, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, dec.forward_drop, dec.learn_host_copy,
           dec.learn_host_queue, dec.age_clear},
          7'h3C);
    bus(1'b1, 8'h04, 32'h0000003E);
    send(5'h04, 48'hA1A2A3A4A5A6, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, dec.forward_drop, dec.age_clear}, 3'h1);
  endtask : t_locked
  task automatic t_service();
    bus(1'b1, 8'h20, 32'h000002AB);
    send(5'h03, 48'h0000000000B0, 1'b0, 1'b0, 1'b0, 5'h00);
    check({lrn.write, lrn.kind, lrn.addr}, 15'h5055);
  endtask : t_service
  task automatic t_skip();
    bus(1'b1, 8'h04, 32'h00000036);
    @(posedge hclk);
    lock_entry <= 1'b1;
    @(posedge hclk);
    lock_entry <= 1'b0;
    send(5'h04, 48'h0000000000B0, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, dec.forward_drop, dec.learn_host_copy,
           dec.age_clear}, 4'h1);
    agg = 1'b1;
    send(5'h03, 48'h0000000000D0, 1'b0, 1'b0, 1'b0, 5'h01);
    agg = 1'b0;
    check({lrn.write, lrn.update_only, lrn.kind, lrn.addr},
          16'h9007);
    bus(1'b1, 8'h20, 32'h00000057);
    send(5'h03, 48'h0000000000E0, 1'b0, 1'b0, 1'b0, 5'h00);
    check({lrn.write, lrn.kind, lrn.addr}, 15'h700A);
    bus(1'b1, 8'h0C, 32'h00000018);
    bus(1'b1, 8'h04, 32'h00000076);
    send(5'h04, 48'h0000000000E0, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, dec.forward_drop, dec.age_clear}, 3'h1);
    bus(1'b1, 8'h04, 32'h00000036);
    send(5'h04, 48'h0000000000E0, 1'b0, 1'b0, 1'b0, 5'h01);
    check({lrn.write, lrn.update_only, dec.forward_drop},
          3'h7);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h00000010);
  endtask : t_skip
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_flood();
    t_learn();
    t_move();
    t_locked();
    t_service();
    t_skip();
    end_sim();
  end
  initial begin
    #1000000;
    err_total++;
    end_sim();
  end
endmodule : l2_forward_source_learn_tb
